// ### sas_analog_model.sv
// Behavioural sample-hold, resistor string and comparator behind the sequencer.
// Assumes the bench supplies one 10-bit input level per channel, packed.
`timescale 1ns/100ps
`default_nettype none

module sas_analog_model (
  input  wire logic        clk_sys,       // Peripheral clock
  input  wire logic        reset_n,       // Sync reset, active low
  input  wire logic [79:0] levels,        // Eight input levels, 10 bits each
  input  wire logic [2:0]  muxSel,        // Input mux select
  input  wire logic        sampleOn,      // Sample-hold tracking
  input  wire logic        comparatorEn,  // Comparator power
  input  wire logic [9:0]  trialCode,     // Resistor tap code
  output logic             compGe         // Held level >= tap
);
  logic [9:0] heldLvl;
  logic       noise;

  // Tracks only while sampling, so the held value survives input changes
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      heldLvl <= 10'h000;
      noise   <= 1'b0;
    end else begin
      if (sampleOn) begin
        heldLvl <= levels[muxSel*10 +: 10];
      end
      noise <= ~noise;
    end
  end

  // Unpowered comparator gives garbage rather than a settled level
  assign compGe = comparatorEn ? (heldLvl >= trialCode) : noise;

endmodule // sas_analog_model

`default_nettype wire

// ### sas_pkg.sv
// Constants, state encoding and timing tables for the APPROX_REG converter sequencer.
// Assumes a single peripheral clock of 125 MHz feeding the whole block.
package sas_pkg;

  localparam int RES_BITS  = 10;
  localparam int WORD_BITS = 16;
  localparam int BYTE_BITS = 8;
  localparam int PAD_BITS  = WORD_BITS - RES_BITS;
  localparam int CHAN_BITS = 3;
  localparam int ADDR_BITS = 3;
  localparam int DATA_BITS = 16;
  localparam int MODE_BITS = 8;
  localparam int CNT_BITS  = 9;
  localparam int DIV_BITS  = 4;
  localparam int IDX_BITS  = 4;

  // Register map, one register per address
  localparam logic [ADDR_BITS-1:0] ADDR_MODE = 3'h0;
  localparam logic [ADDR_BITS-1:0] ADDR_CHAN = 3'h1;
  localparam logic [ADDR_BITS-1:0] ADDR_WORD = 3'h2;
  localparam logic [ADDR_BITS-1:0] ADDR_BYTE = 3'h3;
  localparam logic [ADDR_BITS-1:0] ADDR_STAT = 3'h4;

  // Mode register layout
  localparam int MODE_RUN_BIT = 7;
  localparam int MODE_FR_HI   = 5;
  localparam int MODE_FR_LO   = 3;
  localparam int MODE_LV1_BIT = 2;
  localparam int MODE_LV0_BIT = 1;
  localparam int MODE_CMP_BIT = 0;
  localparam logic [MODE_BITS-1:0] MODE_RESET   = 8'h00;
  localparam logic [MODE_BITS-1:0] MODE_WR_MASK = 8'hbf;

  // Status register layout
  localparam int STAT_SETTLED_BIT = 0;
  localparam int STAT_SUSPECT_BIT = 1;
  localparam int STAT_BUSY_BIT    = 2;

  // Comparator settling time and its cycle count at the system clock
  localparam int CLK_PERIOD_NS   = 8;
  localparam int COMP_SETTLE_NS  = 1000;
  localparam int COMP_SETTLE_CYC = (COMP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_BITS     = 8;

  // One approximation step lasts this many conversion clocks
  localparam int STEP_PER_DIV = 2;
  localparam logic [CNT_BITS-1:0] CNT_LAST = 9'h001;
  localparam logic [RES_BITS-1:0] APPROX_MSB = 10'h200;
  localparam logic [CHAN_BITS-1:0] CODE_LAST = 3'h5;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_SAMPLE  = 2'b01,
    ST_CONVERT = 2'b11,
    ST_XFER    = 2'b10
  } sas_state_type;

  function automatic logic [CNT_BITS-1:0] conv_cycles(input logic [2:0] fr, input logic lv0);
    logic [CNT_BITS-1:0] t;
    t = 9'h000;
    case (fr)
      3'h0: t = lv0 ? 9'd480 : 9'd264;
      3'h1: t = lv0 ? 9'd320 : 9'd176;
      3'h2: t = lv0 ? 9'd240 : 9'd132;
      3'h3: t = lv0 ? 9'd160 : 9'd88;
      3'h4: t = lv0 ? 9'd120 : 9'd66;
      3'h5: t = lv0 ? 9'd80  : 9'd44;
      default: t = 9'h000;
    endcase
    return t;
  endfunction

  function automatic logic [DIV_BITS-1:0] conv_divisor(input logic [2:0] fr);
    logic [DIV_BITS-1:0] d;
    d = 4'h0;
    case (fr)
      3'h0: d = 4'd12;
      3'h1: d = 4'd8;
      3'h2: d = 4'd6;
      3'h3: d = 4'd4;
      3'h4: d = 4'd3;
      3'h5: d = 4'd2;
      default: d = 4'h0;
    endcase
    return d;
  endfunction

endpackage

// ### sas_sequencer.sv
// APPROX_REG converter sequencer: mode/channel registers, sample-hold and approximation control.
// Assumes an external comparator whose result arrives asynchronously on compGe.
//
// Notes on behaviour
// RL1 - Ten-bit result from one of eight inputs
// RL2 - Run set: convert selected input repeatedly
// RL3 - Completion pulse after every conversion
// RL4 - Unselected pins stay free for digital use
// RL5 - Sample at start, hold until finish
// RL6 - Resolve MSB to LSB, then copy out
// RL7 - Word holds result high, low six zero
// RL8 - Byte holds upper eight result bits
// RL9 - Result reads flag a wait cycle
// RL10 - Reset clears mode register to zero
// RL11 - Run and comparator bits give four modes
// RL12 - Comparator needs 1 us before trusted result
// RL13 - Software writes zero to mode bit six
// RL14 - Stop before changing clock or voltage selects
// RL15 - Mode writes flag a wait cycle
// RL16 - Normal mode: 264 to 44 clock conversions
// RL17 - Low-voltage mode: 480 to 80 clock conversions
// RL18 - Software keeps conversion clock within limits
// RL19 - Trial-set each bit from bit 9 down
// RL20 - Repeat until run bit is cleared
// RL21 - Three-bit field selects the input
// RL22 - Clearing run abandons conversion without result
`timescale 1ns/100ps
`default_nettype none

module sas_sequencer #(
  parameter int NUM_INPUTS = 8
) (
  input  wire logic                          clk_sys,       // Peripheral clock
  input  wire logic                          reset_n,       // Sync reset, active low
  input  wire logic [sas_pkg::ADDR_BITS-1:0] regAddr,       // Register address
  input  wire logic [sas_pkg::DATA_BITS-1:0] regWrData,     // Write data
  input  wire logic                          regWrStrobe,   // Write strobe
  input  wire logic                          regRdStrobe,   // Read strobe
  output logic      [sas_pkg::DATA_BITS-1:0] regRdData,     // Read data, next cycle
  output logic                               busWait,       // Wait cycle request
  input  wire logic                          compGe,        // Comparator: input >= tap
  output logic                               comparatorEn,  // Comparator power
  output logic                               lowVoltMode,   // Low-voltage select
  output logic                               sampleOn,      // Sample-hold tracking
  output logic                               holdOn,        // Sample-hold holding
  output logic      [sas_pkg::RES_BITS-1:0]  trialCode,     // Resistor tap code
  output logic      [sas_pkg::CHAN_BITS-1:0] muxSel,        // Input mux select
  output logic      [NUM_INPUTS-1:0]         analogPinSel,  // Pins tied to the mux
  output logic                               convDoneIrq    // Completion pulse
);

  if (NUM_INPUTS < 1 || NUM_INPUTS > (1 << sas_pkg::CHAN_BITS)) begin : g_chk
    $error("NUM_INPUTS out of range");
  end

  // Register group
  logic [sas_pkg::MODE_BITS-1:0] mode_ff, nxt_mode;
  logic [sas_pkg::CHAN_BITS-1:0] chanSel_ff, nxt_chanSel;
  logic [sas_pkg::DATA_BITS-1:0] rdData_ff, nxt_rdData;

  // Converter group
  sas_pkg::sas_state_type          state_ff, nxt_state;
  logic [sas_pkg::CNT_BITS-1:0]    cnt_ff, nxt_cnt;
  logic [sas_pkg::IDX_BITS-1:0]    bitIdx_ff, nxt_bitIdx;
  logic [sas_pkg::RES_BITS-1:0]    approx_ff, nxt_approx;
  logic [sas_pkg::WORD_BITS-1:0]   resultWord_ff, nxt_resultWord;
  logic [sas_pkg::BYTE_BITS-1:0]   resultByte_ff, nxt_resultByte;
  logic                            irq_ff, nxt_irq;
  logic [sas_pkg::CHAN_BITS-1:0]   heldChan_ff, nxt_heldChan;
  logic [sas_pkg::SETTLE_BITS-1:0] settle_ff, nxt_settle;
  logic                            suspect_ff, nxt_suspect;
  logic [1:0]                      compSync_ff, nxt_compSync;

  logic                          runBit;
  logic                          cmpBit;
  logic [2:0]                    frCode;
  logic                          codeLegal;
  logic                          settled;
  logic                          goStart;
  logic [sas_pkg::CNT_BITS-1:0]  bitLen;
  logic [sas_pkg::CNT_BITS-1:0]  sampleLen;

  assign runBit    = mode_ff[sas_pkg::MODE_RUN_BIT];
  assign cmpBit    = mode_ff[sas_pkg::MODE_CMP_BIT];
  assign frCode    = mode_ff[sas_pkg::MODE_FR_HI:sas_pkg::MODE_FR_LO];
  // Prohibited clock or voltage codes simply never start a conversion
  assign codeLegal = (frCode <= sas_pkg::CODE_LAST) && !mode_ff[sas_pkg::MODE_LV1_BIT];
  assign settled   = (settle_ff == sas_pkg::SETTLE_BITS'(sas_pkg::COMP_SETTLE_CYC));
  // Bit step is two conversion clocks; sampling takes the rest of the time
  assign bitLen    = sas_pkg::CNT_BITS'(sas_pkg::STEP_PER_DIV)
                   * {5'h0, sas_pkg::conv_divisor(frCode)};                          // RL16 RL17
  assign sampleLen = sas_pkg::conv_cycles(frCode, mode_ff[sas_pkg::MODE_LV0_BIT])
                   - sas_pkg::CNT_BITS'(sas_pkg::RES_BITS) * bitLen;                // RL16 RL17
  assign goStart   = runBit && codeLegal
                   && (state_ff == sas_pkg::ST_IDLE || state_ff == sas_pkg::ST_XFER); // RL2

  // Registers and read port
  always_comb begin
    nxt_mode    = mode_ff;
    nxt_chanSel = chanSel_ff;
    nxt_rdData  = '0;
    if (regWrStrobe) begin
      case (regAddr)
        // Bit six is stored as zero whatever is written
        sas_pkg::ADDR_MODE: nxt_mode = regWrData[sas_pkg::MODE_BITS-1:0] & sas_pkg::MODE_WR_MASK;
        sas_pkg::ADDR_CHAN: nxt_chanSel = regWrData[sas_pkg::CHAN_BITS-1:0];             // RL21
        default: ;
      endcase
    end
    if (regRdStrobe) begin
      case (regAddr)
        sas_pkg::ADDR_MODE: nxt_rdData = {8'h00, mode_ff};
        sas_pkg::ADDR_CHAN: nxt_rdData = {13'h0000, chanSel_ff};
        sas_pkg::ADDR_WORD: nxt_rdData = resultWord_ff;
        sas_pkg::ADDR_BYTE: nxt_rdData = {8'h00, resultByte_ff};
        sas_pkg::ADDR_STAT: begin
          nxt_rdData[sas_pkg::STAT_SETTLED_BIT] = settled;
          nxt_rdData[sas_pkg::STAT_SUSPECT_BIT] = suspect_ff;
          nxt_rdData[sas_pkg::STAT_BUSY_BIT]    = (state_ff != sas_pkg::ST_IDLE);
        end
        default: nxt_rdData = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      mode_ff    <= sas_pkg::MODE_RESET;                                              // RL10
      chanSel_ff <= '0;
      rdData_ff  <= '0;
    end else begin
      mode_ff    <= nxt_mode;
      chanSel_ff <= nxt_chanSel;
      rdData_ff  <= nxt_rdData;
    end
  end

  // Sequencer: sample, approximate, transfer
  always_comb begin
    nxt_state      = state_ff;
    nxt_cnt        = cnt_ff;
    nxt_bitIdx     = bitIdx_ff;
    nxt_approx     = approx_ff;
    nxt_resultWord = resultWord_ff;
    nxt_resultByte = resultByte_ff;
    nxt_irq        = 1'b0;
    nxt_heldChan   = heldChan_ff;
    nxt_suspect    = suspect_ff;
    nxt_compSync   = {compSync_ff[0], compGe};
    // Settling restarts whenever the comparator is powered down
    if (!cmpBit) begin
      nxt_settle = '0;                                                                // RL12
    end else if (!settled) begin
      nxt_settle = settle_ff + 1'b1;                                                  // RL12
    end else begin
      nxt_settle = settle_ff;
    end
    unique case (state_ff)
      sas_pkg::ST_IDLE: ;
      sas_pkg::ST_SAMPLE: begin
        if (!runBit) begin
          nxt_state = sas_pkg::ST_IDLE;                                               // RL22
        end else if (cnt_ff == sas_pkg::CNT_LAST) begin
          nxt_state  = sas_pkg::ST_CONVERT;
          nxt_cnt    = bitLen;
          nxt_bitIdx = sas_pkg::IDX_BITS'(sas_pkg::RES_BITS - 1);
          nxt_approx = sas_pkg::APPROX_MSB;                                           // RL19
        end else begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
      sas_pkg::ST_CONVERT: begin
        if (!runBit) begin
          nxt_state = sas_pkg::ST_IDLE;                                               // RL22
        end else if (cnt_ff == sas_pkg::CNT_LAST) begin
          nxt_approx[bitIdx_ff] = compSync_ff[1];                                     // RL19
          if (bitIdx_ff == '0) begin
            nxt_state = sas_pkg::ST_XFER;                                             // RL6
          end else begin
            nxt_approx[bitIdx_ff - 1'b1] = 1'b1;                                      // RL19
            nxt_bitIdx = bitIdx_ff - 1'b1;
            nxt_cnt    = bitLen;
          end
        end else begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
      sas_pkg::ST_XFER: begin
        nxt_resultWord = {approx_ff, sas_pkg::PAD_BITS'(0)};                          // RL6 RL7
        nxt_resultByte = approx_ff[sas_pkg::RES_BITS-1 -: sas_pkg::BYTE_BITS];        // RL8
        nxt_irq        = 1'b1;                                                        // RL3
        nxt_state      = sas_pkg::ST_IDLE;
      end
    endcase
    if (goStart) begin
      // Channel is latched so a mid-conversion select change waits
      nxt_state    = sas_pkg::ST_SAMPLE;                                              // RL2 RL20
      nxt_cnt      = sampleLen;
      nxt_heldChan = chanSel_ff;                                                      // RL5
      nxt_approx   = '0;
      nxt_suspect  = !settled;                                                        // RL12
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state_ff      <= sas_pkg::ST_IDLE;
      cnt_ff        <= '0;
      bitIdx_ff     <= '0;
      approx_ff     <= '0;
      resultWord_ff <= '0;
      resultByte_ff <= '0;
      irq_ff        <= 1'b0;
      heldChan_ff   <= '0;
      settle_ff     <= '0;
      suspect_ff    <= 1'b0;
      compSync_ff   <= '0;
    end else begin
      state_ff      <= nxt_state;
      cnt_ff        <= nxt_cnt;
      bitIdx_ff     <= nxt_bitIdx;
      approx_ff     <= nxt_approx;
      resultWord_ff <= nxt_resultWord;
      resultByte_ff <= nxt_resultByte;
      irq_ff        <= nxt_irq;
      heldChan_ff   <= nxt_heldChan;
      settle_ff     <= nxt_settle;
      suspect_ff    <= nxt_suspect;
      compSync_ff   <= nxt_compSync;
    end
  end

  assign regRdData    = rdData_ff;
  assign busWait      = (regWrStrobe && regAddr == sas_pkg::ADDR_MODE)                // RL15
                     || (regRdStrobe && (regAddr == sas_pkg::ADDR_WORD
                                      || regAddr == sas_pkg::ADDR_BYTE));             // RL9
  assign comparatorEn = cmpBit;                                                       // RL11
  assign lowVoltMode  = mode_ff[sas_pkg::MODE_LV0_BIT];
  assign sampleOn     = (state_ff == sas_pkg::ST_SAMPLE);                             // RL5
  assign holdOn       = (state_ff == sas_pkg::ST_CONVERT);                            // RL5
  assign trialCode    = approx_ff;                                                    // RL1
  assign muxSel       = heldChan_ff;                                                  // RL1
  assign convDoneIrq  = irq_ff;                                                       // RL3

  // Only the selected pin is claimed while the converter is in use
  for (genvar i = 0; i < NUM_INPUTS; i++) begin : g_pin
    assign analogPinSel[i] = (runBit || cmpBit)
                          && (chanSel_ff == sas_pkg::CHAN_BITS'(i));                  // RL4
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  AST_IRQ_AFTER_XFER: assert property (state_ff == sas_pkg::ST_XFER |=> convDoneIrq) // RL3
    else $error("completion pulse missing");
  AST_IRQ_SINGLE: assert property (convDoneIrq |=> !convDoneIrq) // RL3
    else $error("completion pulse too long");
  AST_WORD_LOAD: assert property (convDoneIrq |-> // RL7
    resultWord_ff == {$past(approx_ff), sas_pkg::PAD_BITS'(0)})
    else $error("result word mismatch");
  AST_BYTE_LOAD: assert property (convDoneIrq |-> // RL8
    resultByte_ff == $past(approx_ff[sas_pkg::RES_BITS-1 -: sas_pkg::BYTE_BITS]))
    else $error("result byte mismatch");
  AST_MSB_FIRST: assert property ((state_ff == sas_pkg::ST_SAMPLE) ##1
    (state_ff == sas_pkg::ST_CONVERT) |-> trialCode == 10'h200 && bitIdx_ff == 4'h9) // RL19
    else $error("approximation not starting at top bit");
  AST_ABORT: assert property (!runBit && (state_ff == sas_pkg::ST_SAMPLE
    || state_ff == sas_pkg::ST_CONVERT) |=> state_ff == sas_pkg::ST_IDLE ##1 !convDoneIrq) // RL22
    else $error("abandoned conversion not dropped");
  AST_RESTART: assert property (state_ff == sas_pkg::ST_XFER && runBit && codeLegal
    |=> state_ff == sas_pkg::ST_SAMPLE) // RL2
    else $error("no restart after completion");
  AST_HOLD_CHAN: assert property (holdOn && $past(holdOn) |-> $stable(muxSel)) // RL5
    else $error("held channel changed");
  AST_RESET_MODE: assert property (disable iff (1'b0) !reset_n |=> mode_ff == 8'h00) // RL10
    else $error("mode not cleared by reset");
  AST_READ_WAIT: assert property (regRdStrobe && regAddr == sas_pkg::ADDR_WORD
    |-> busWait ##1 regRdData == $past(resultWord_ff)) // RL9
    else $error("result read missing wait or data");
  AST_SUSPECT: assert property ($rose(sampleOn) && !cmpBit |-> suspect_ff) // RL12
    else $error("unsettled start not flagged");

  // Register side and sequencing corners
  AST_WRITE_WAIT: assert property (regWrStrobe && regAddr == sas_pkg::ADDR_MODE // RL15
    |-> busWait)
    else $error("mode write missing wait flag");
  AST_BIT6_CLEAR: assert property ((mode_ff & ~sas_pkg::MODE_WR_MASK) == '0) // RL13
    else $error("reserved mode bit stored as one");
  AST_BAD_CODE: assert property (!codeLegal && state_ff == sas_pkg::ST_IDLE // RL16 RL17
    |=> state_ff == sas_pkg::ST_IDLE)
    else $error("prohibited clock code started a conversion");
  AST_LAST_STEP: assert property (holdOn && runBit && cnt_ff == sas_pkg::CNT_LAST // RL6
    && bitIdx_ff == '0 |=> state_ff == sas_pkg::ST_XFER)
    else $error("no transfer after the last bit");
  AST_PIN_SINGLE: assert property ($onehot0(analogPinSel)) // RL4
    else $error("more than one pin claimed");
  AST_STOP_IDLE: assert property (!runBit && state_ff == sas_pkg::ST_IDLE // RL11
    |=> !sampleOn && !holdOn)
    else $error("conversion started while stopped");
  AST_IRQ_SOURCE: assert property (convDoneIrq |-> $past(state_ff) == sas_pkg::ST_XFER) // RL3
    else $error("completion pulse without transfer");

endmodule // sas_sequencer

`default_nettype wire

// ### tb_top.sv
// Self-checking bench for the APPROX_REG sequencer with the analog partner model.
// Assumes a 125 MHz clock and the register map of the sequencer package.
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  logic        clk_sys     = 1'b0;
  logic        reset_n     = 1'b0;
  logic [2:0]  regAddr     = 3'h0;
  logic [15:0] regWrData   = 16'h0000;
  logic        regWrStrobe = 1'b0;
  logic        regRdStrobe = 1'b0;
  logic [79:0] levels      = 80'h0;
  logic        rdValid     = 1'b0;
  logic        prevIrq     = 1'b0;
  logic [15:0] regRdData;
  logic        busWait, compGe, comparatorEn, lowVoltMode, sampleOn, holdOn, convDoneIrq;
  logic [9:0]  trialCode, lvl, nxtLvl;
  logic [2:0]  muxSel, ch;
  logic [7:0]  analogPinSel, mode;
  logic [15:0] expQ[$];
  int          err_count = 0;
  int          samples_checked = 0;
  int          irqCount = 0;
  int          seed = 12;
  int          fr, lv, n, k, t;
  int          tNorm[6] = '{264, 176, 132, 88, 66, 44};
  int          tLow[6]  = '{480, 320, 240, 160, 120, 80};
  logic [15:0] badCodes[2] = '{16'h00b1, 16'h00ad};

  always #4 clk_sys = ~clk_sys;

  sas_sequencer #(.NUM_INPUTS(8)) dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe), .regRdData(regRdData),
    .busWait(busWait), .compGe(compGe), .comparatorEn(comparatorEn),
    .lowVoltMode(lowVoltMode), .sampleOn(sampleOn), .holdOn(holdOn),
    .trialCode(trialCode), .muxSel(muxSel), .analogPinSel(analogPinSel),
    .convDoneIrq(convDoneIrq));

  sas_analog_model far (
    .clk_sys(clk_sys), .reset_n(reset_n), .levels(levels), .muxSel(muxSel),
    .sampleOn(sampleOn), .comparatorEn(comparatorEn), .trialCode(trialCode),
    .compGe(compGe));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    regAddr     <= a;
    regWrData   <= d;
    regWrStrobe <= 1'b1;
    @(negedge clk_sys);
    check({15'h0, busWait}, {15'h0, a == sas_pkg::ADDR_MODE});
    @(posedge clk_sys);
    regWrStrobe <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, input logic [15:0] exp);
    expQ.push_back(exp);
    @(posedge clk_sys);
    regAddr     <= a;
    regRdStrobe <= 1'b1;
    @(negedge clk_sys);
    check({15'h0, busWait}, {15'h0, a == sas_pkg::ADDR_WORD || a == sas_pkg::ADDR_BYTE});
    @(posedge clk_sys);
    regRdStrobe <= 1'b0;
  endtask

  task automatic tally_and_finish();
    if (err_count == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge clk_sys) begin
    rdValid <= regRdStrobe;
    prevIrq <= convDoneIrq;
    if (convDoneIrq === 1'b1) irqCount <= irqCount + 1;
  end

  // Read data stand only in the cycle after the strobe
  always @(negedge clk_sys) begin
    if (rdValid) check(regRdData, expQ.pop_front());
    if (prevIrq === 1'b1) check({15'h0, convDoneIrq}, 16'h0000);
  end

  initial begin
    #200000;
    err_count++;
    tally_and_finish();
  end

  initial begin
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    rd(sas_pkg::ADDR_MODE, 16'h0000);
    rd(sas_pkg::ADDR_WORD, 16'h0000);
    rd(sas_pkg::ADDR_BYTE, 16'h0000);
    wr(sas_pkg::ADDR_WORD, 16'hffff);
    rd(sas_pkg::ADDR_WORD, 16'h0000);
    rd(3'h7, 16'h0000);
    wr(sas_pkg::ADDR_MODE, 16'h0041);
    rd(sas_pkg::ADDR_MODE, 16'h0001);
    check({15'h0, comparatorEn}, 16'h0001);
    rd(sas_pkg::ADDR_STAT, 16'h0000);
    repeat (130) @(posedge clk_sys);
    rd(sas_pkg::ADDR_STAT, 16'h0001);
    for (fr = 0; fr < 6; fr++) begin
      for (lv = 0; lv < 2; lv++) begin
        ch     = 3'($random(seed));
        lvl    = 10'($random(seed));
        nxtLvl = 10'($random(seed));
        t      = lv ? tLow[fr] : tNorm[fr];
        levels[ch*10 +: 10] <= lvl;
        mode = {2'b00, 3'(fr), 1'b0, 1'(lv), 1'b1};
        wr(sas_pkg::ADDR_CHAN, {13'h0, ch});
        wr(sas_pkg::ADDR_MODE, {8'h00, mode});
        wr(sas_pkg::ADDR_MODE, {8'h00, mode | 8'h80});
        n = 0;
        k = 0;
        while (convDoneIrq !== 1'b1 && n < 1000) begin
          @(posedge clk_sys);
          #1;
          n++;
          if (holdOn === 1'b1 && k == 0) begin
            levels[ch*10 +: 10] = nxtLvl;
            k = 1;
          end
        end
        // Run lands one edge after the write, start one edge later, pulse after transfer
        check(16'(n), 16'(t + 2));
        check({13'h0, muxSel}, {13'h0, ch});
        check({8'h00, analogPinSel}, {8'h00, 8'h01 << ch});
        check({15'h0, lowVoltMode}, 16'(lv));
        rd(sas_pkg::ADDR_WORD, {lvl, 6'h00});
        rd(sas_pkg::ADDR_BYTE, {8'h00, lvl[9:2]});
        n = 4;
        while (convDoneIrq !== 1'b1 && n < 1000) begin
          @(posedge clk_sys);
          #1;
          n++;
        end
        check(16'(n), 16'(t + 1));
        rd(sas_pkg::ADDR_WORD, {nxtLvl, 6'h00});
        wr(sas_pkg::ADDR_MODE, {8'h00, mode});
      end
    end
    // Abandoned conversion must leave the last result in place
    levels[ch*10 +: 10] <= ~nxtLvl;
    wr(sas_pkg::ADDR_MODE, 16'h0029);
    wr(sas_pkg::ADDR_MODE, 16'h00a9);
    n = irqCount;
    k = 0;
    while (holdOn !== 1'b1 && k < 100) begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    wr(sas_pkg::ADDR_MODE, 16'h0029);
    repeat (100) @(posedge clk_sys);
    check(16'(irqCount), 16'(n));
    check({15'h0, holdOn}, 16'h0000);
    rd(sas_pkg::ADDR_WORD, {nxtLvl, 6'h00});
    for (fr = 0; fr < 2; fr++) begin
      wr(sas_pkg::ADDR_MODE, badCodes[fr] & 16'h007f);
      wr(sas_pkg::ADDR_MODE, badCodes[fr]);
      k = 0;
      repeat (60) begin
        @(posedge clk_sys);
        #1;
        if (sampleOn === 1'b1) k++;
      end
      check(16'(k), 16'h0000);
      wr(sas_pkg::ADDR_MODE, badCodes[fr] & 16'h007f);
    end
    // Run with comparator off still converts, but the result is flagged suspect
    wr(sas_pkg::ADDR_MODE, 16'h0028);
    wr(sas_pkg::ADDR_MODE, 16'h00a8);
    n = 0;
    while (convDoneIrq !== 1'b1 && n < 1000) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    check(16'(n), 16'h002e);
    check({15'h0, comparatorEn}, 16'h0000);
    rd(sas_pkg::ADDR_STAT, 16'h0006);
    wr(sas_pkg::ADDR_MODE, 16'h0028);
    // Reset in mid-conversion
    wr(sas_pkg::ADDR_MODE, 16'h0029);
    wr(sas_pkg::ADDR_MODE, 16'h00a9);
    repeat (10) @(posedge clk_sys);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    rd(sas_pkg::ADDR_MODE, 16'h0000);
    rd(sas_pkg::ADDR_WORD, 16'h0000);
    check({14'h0, comparatorEn, sampleOn | holdOn}, 16'h0000);
    repeat (4) @(posedge clk_sys);
    tally_and_finish();
  end

endmodule // tb_top

`default_nettype wire
